// File: rtl/pmra_core.sv
`timescale 1ns/1ps
`include "pmra_consts.svh"
// How it works
// - Current result is signed, 1.25 mA step.
// - Results hold averaged values when averaging.
// - Bus result steps 1.25 mV, 32767 full.
// - Bus result top bit always zero.
// - Power count fixed at 10 mW.
// - Power is current times bus voltage.
// - Power stored as non-negative magnitude.
// - Power never above code A3D7h.
// - Highest enabled limit function wins.
// - Over limits alert when measurement exceeds.
// - Under limits alert when measurement below.
// - Power limit checked after bus measurement.
// - Ready alert follows conversion-done flag.
// - Limit-source flag shows limit caused alert.
// - Latch mode: flag clears on select read.
// - Transparent: flag clears after clean conversion.
// - Done flag set after full cycle finished.
// - Done flag clears on config write without power-down, select read.
// - Results readable anytime, last completed data.
// - Overflow flag set when power overflows.
// - Polarity bit picks alert active level.
// - Latch holds alert until read, else idles.
// - Limit compared in selected result's format.
module pmra_core
  import pmra_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Register access from the serial engine.
  input wire pmra_reg_req_s i_req,
  output logic [15:0] o_rdata,
  // Conversion results and configuration events from the front end.
  input wire pmra_meas_s i_meas,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_pdown,
  // Open-collector alert pin.
  output logic o_alert_o,
  output logic o_alert_oe
);

  // Divider from raw product to 10 mW counts, derived from the step sizes.
  localparam logic [31:0] POWER_DIV =
    32'(`PMRA_PWR_LSB_PW / (`PMRA_CUR_LSB_UA * `PMRA_BUS_LSB_UV));

  // Stored state.
  logic [15:0] current_result; // Signed current result.
  logic [15:0] bus_voltage_result; // Bus voltage result.
  logic [15:0] power_result; // Power result.
  logic [15:0] alert_select; // Writable select bits only.
  logic [15:0] alert_limit; // Alert limit.
  logic limit_source_flag; // Limit-source flag.
  logic conversion_done_flag; // Conversion-done flag.
  logic math_overflow_flag; // Math overflow flag.
  logic calc_pend; // Power and compare stage pending.
  logic upd_cur; // Current was part of the last conversion.
  logic upd_bus; // Bus voltage was part of the last conversion.
  logic alert_oe; // Registered pin enable.
  logic [15:0] rdata; // Registered read data.
  // Next values.
  logic [15:0] next_current_result, next_bus_voltage_result, next_power_result;
  logic [15:0] next_alert_select, next_alert_limit, next_rdata;
  logic next_limit_source_flag, next_conversion_done_flag, next_math_overflow_flag;
  logic next_calc_pend, next_upd_cur, next_upd_bus;
  logic next_alert_oe;
  // Arithmetic and decode helpers.
  logic [15:0] cur_mag; // Magnitude of the current.
  logic [30:0] product; // Raw current times bus product.
  logic [31:0] quotient; // Product in 10 mW counts.
  logic overflow_now; // Product beyond the reportable code.
  logic [15:0] pwr_now; // Clamped power for this conversion.
  pmra_func_e func; // Selected limit function.
  logic evaluated; // Selected function saw a fresh measurement.
  logic hit; // Limit condition met.
  logic mask_rd; // Read of the alert select register.
  logic alert_active; // Alert condition before polarity.
  logic [15:0] mask_view; // Alert select register as read.

  // Arithmetic, function select and the next value of every register.
  always_comb begin
    mask_rd = i_req.rd && (i_req.addr == `PMRA_OFS_MASK);
    cur_mag = current_result[15] ? 16'(~current_result + 16'h0001) : current_result;
    // current times voltage
    // Both operands are widened first so the product keeps all 31 bits.
    product = 31'({15'h0000, cur_mag} * {16'h0000, bus_voltage_result[14:0]});
    quotient = 32'(product) / POWER_DIV;
    overflow_now = quotient > {16'h0000, `PMRA_POWER_MAX};
    pwr_now = overflow_now ? `PMRA_POWER_MAX : quotient[15:0];
    if (alert_select[`PMRA_BIT_OVER_CUR]) begin
      func = PMRA_FN_OVER_CUR;
    end else if (alert_select[`PMRA_BIT_UNDER_CUR]) begin
      func = PMRA_FN_UNDER_CUR;
    end else if (alert_select[`PMRA_BIT_RAIL_OVER]) begin
      func = PMRA_FN_RAIL_OVER;
    end else if (alert_select[`PMRA_BIT_RAIL_UNDER]) begin
      func = PMRA_FN_RAIL_UNDER;
    end else if (alert_select[`PMRA_BIT_POWER_OVER]) begin
      func = PMRA_FN_POWER_OVER;
    end else begin
      func = PMRA_FN_NONE;
    end
    case (func)
      PMRA_FN_OVER_CUR: begin
        evaluated = upd_cur;
        hit = $signed(current_result) > $signed(alert_limit);
      end
      PMRA_FN_UNDER_CUR: begin
        evaluated = upd_cur;
        hit = $signed(current_result) < $signed(alert_limit);
      end
      PMRA_FN_RAIL_OVER: begin
        evaluated = upd_bus;
        hit = bus_voltage_result > alert_limit;
      end
      PMRA_FN_RAIL_UNDER: begin
        evaluated = upd_bus;
        hit = bus_voltage_result < alert_limit;
      end
      PMRA_FN_POWER_OVER: begin
        evaluated = upd_bus;
        hit = pwr_now > alert_limit;
      end
      default: begin
        evaluated = 1'b0;
        hit = 1'b0;
      end
    endcase

    // Stage one captures the conversion; results keep old data otherwise.
    next_current_result = current_result;
    next_bus_voltage_result = bus_voltage_result;
    next_upd_cur = upd_cur;
    next_upd_bus = upd_bus;
    next_calc_pend = i_meas.valid;
    if (i_meas.valid) begin
      next_upd_cur = i_meas.cur_upd;
      next_upd_bus = i_meas.bus_upd;
      if (i_meas.cur_upd) begin
        next_current_result = i_meas.cur;
      end
      // reading kept in 1.25 mV counts
      if (i_meas.bus_upd) begin
        next_bus_voltage_result = {1'b0, i_meas.bus[14:0]};
      end
    end

    // Stage two writes power, the overflow and done flags.
    next_power_result = power_result;
    next_math_overflow_flag = math_overflow_flag;
    next_conversion_done_flag = conversion_done_flag;
    if ((i_cfg_wr && !i_cfg_pdown) || mask_rd) begin
      next_conversion_done_flag = 1'b0;
    end
    // Overflow is cleared by reading the select register.
    if (mask_rd) begin
      next_math_overflow_flag = 1'b0;
    end
    if (calc_pend) begin
      next_power_result = pwr_now;
      if (overflow_now) begin
        next_math_overflow_flag = 1'b1;
      end
      next_conversion_done_flag = 1'b1;
    end

    next_limit_source_flag = limit_source_flag;
    if (alert_select[`PMRA_BIT_LATCH]) begin
      if (mask_rd) begin
        next_limit_source_flag = 1'b0;
      end
    end else if (calc_pend && evaluated && !hit) begin
      next_limit_source_flag = 1'b0;
    end
    // A new fault wins over any clear in the same cycle.
    if (calc_pend && evaluated && hit) begin
      next_limit_source_flag = 1'b1;
    end

    // Register writes; only the select and limit registers accept data.
    next_alert_select = alert_select;
    next_alert_limit = alert_limit;
    if (i_req.wr && (i_req.addr == `PMRA_OFS_MASK)) begin
      next_alert_select = i_req.wdata & `PMRA_MASK_WR;
    end
    if (i_req.wr && (i_req.addr == `PMRA_OFS_LIMIT)) begin
      next_alert_limit = i_req.wdata;
    end

    mask_view = alert_select;
    mask_view[`PMRA_BIT_LIMIT_FLAG] = limit_source_flag;
    mask_view[`PMRA_BIT_DONE_FLAG] = conversion_done_flag;
    mask_view[`PMRA_BIT_OVERFLOW_FLAG] = math_overflow_flag;
    next_rdata = rdata;
    if (i_req.rd) begin
      case (i_req.addr)
        `PMRA_OFS_CURRENT: next_rdata = current_result;
        `PMRA_OFS_BUS: next_rdata = bus_voltage_result;
        `PMRA_OFS_POWER: next_rdata = power_result;
        `PMRA_OFS_MASK: next_rdata = mask_view;
        `PMRA_OFS_LIMIT: next_rdata = alert_limit;
        default: next_rdata = `PMRA_RST_REG;
      endcase
    end

    alert_active = limit_source_flag
      || (alert_select[`PMRA_BIT_READY_ALERT] && conversion_done_flag);
    next_alert_oe = alert_active ^ alert_select[`PMRA_BIT_POLARITY];
  end

  // Registers only; synchronous reset to documented defaults.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      current_result <= `PMRA_RST_REG;
      bus_voltage_result <= `PMRA_RST_REG;
      power_result <= `PMRA_RST_REG;
      alert_select <= `PMRA_RST_REG;
      alert_limit <= `PMRA_RST_REG;
      rdata <= `PMRA_RST_REG;
      limit_source_flag <= 1'b0;
      conversion_done_flag <= 1'b0;
      math_overflow_flag <= 1'b0;
      calc_pend <= 1'b0;
      upd_cur <= 1'b0;
      upd_bus <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      current_result <= next_current_result;
      bus_voltage_result <= next_bus_voltage_result;
      power_result <= next_power_result;
      alert_select <= next_alert_select;
      alert_limit <= next_alert_limit;
      rdata <= next_rdata;
      limit_source_flag <= next_limit_source_flag;
      conversion_done_flag <= next_conversion_done_flag;
      math_overflow_flag <= next_math_overflow_flag;
      calc_pend <= next_calc_pend;
      upd_cur <= next_upd_cur;
      upd_bus <= next_upd_bus;
      alert_oe <= next_alert_oe;
    end
  end

  // The pin only ever pulls low; the pull-up gives the high level.
  assign o_alert_o = 1'b0;
  assign o_alert_oe = alert_oe;
  assign o_rdata = rdata;

  // Checks on the design's own outputs and state.
  a_bus_top_zero:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_req.rd && (i_req.addr == `PMRA_OFS_BUS) |=> o_rdata[15] == 1'b0)
    else $error("bus result top bit not zero");
  a_power_bounded:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    power_result <= `PMRA_POWER_MAX)
    else $error("power result above maximum code");
  a_done_after_calc:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_meas.valid |-> ##2 conversion_done_flag)
    else $error("done flag not set after power stage");
  a_done_read_clear:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    mask_rd && !calc_pend |=> !conversion_done_flag)
    else $error("done flag survived select read");
  a_latch_flag_hold:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    limit_source_flag && alert_select[`PMRA_BIT_LATCH] && !mask_rd |=> limit_source_flag)
    else $error("latched limit flag dropped without read");
  // The pin lags the flag by one edge, so its allowances are taken one cycle back.
  a_trans_flag_clear:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    calc_pend && !alert_select[`PMRA_BIT_LATCH] && evaluated && !hit |=>
      !limit_source_flag ##1 (!o_alert_oe || $past(alert_select[`PMRA_BIT_POLARITY])
      || $past(alert_select[`PMRA_BIT_READY_ALERT] && conversion_done_flag)))
    else $error("transparent flag kept after clean conversion");
  a_pin_polarity:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ##1 o_alert_oe == ($past(alert_active) ^ $past(alert_select[`PMRA_BIT_POLARITY])))
    else $error("alert pin enable disagrees with polarity");
  a_overflow_clamp:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    calc_pend && overflow_now |=> math_overflow_flag && (power_result == `PMRA_POWER_MAX))
    else $error("overflow not flagged or power not clamped");
  a_unused_zero:
  assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    mask_rd |=> o_rdata[9:5] == 5'h00)
    else $error("unused select bits read nonzero");
endmodule // pmra_core

// File: rtl/pmra_consts.svh
`ifndef PMRA_CONSTS_SVH
`define PMRA_CONSTS_SVH
// Register pointer values.
`define PMRA_OFS_CURRENT 8'h01
`define PMRA_OFS_BUS 8'h02
`define PMRA_OFS_POWER 8'h03
`define PMRA_OFS_MASK 8'h06
`define PMRA_OFS_LIMIT 8'h07
// Alert select and flag bit positions.
`define PMRA_BIT_OVER_CUR 15
`define PMRA_BIT_UNDER_CUR 14
`define PMRA_BIT_RAIL_OVER 13
`define PMRA_BIT_RAIL_UNDER 12
`define PMRA_BIT_POWER_OVER 11
`define PMRA_BIT_READY_ALERT 10
`define PMRA_BIT_LIMIT_FLAG 4
`define PMRA_BIT_DONE_FLAG 3
`define PMRA_BIT_OVERFLOW_FLAG 2
`define PMRA_BIT_POLARITY 1
`define PMRA_BIT_LATCH 0
// Reset values and the writable part of the alert select register.
`define PMRA_RST_REG 16'h0000
`define PMRA_MASK_WR 16'hFC03
// Scaling: 1.25 mA, 1.25 mV and 10 mW steps, in uA, uV and pW.
`define PMRA_CUR_LSB_UA 64'h0000_0000_0000_04E2
`define PMRA_BUS_LSB_UV 64'h0000_0000_0000_04E2
`define PMRA_PWR_LSB_PW 64'h0000_0002_540B_E400
// Largest power code that may be reported.
`define PMRA_POWER_MAX 16'hA3D7
`endif

// File: rtl/pmra_pkg.sv
package pmra_pkg;
  // One finished conversion from the front end (already averaged when averaging is on).
  typedef struct packed {
    logic valid;
    logic cur_upd;
    logic bus_upd;
    logic [15:0] cur;
    logic [15:0] bus;
  } pmra_meas_s;
  // One register access from the serial engine.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pmra_reg_req_s;
  // Limit function chosen by priority from the enable bits.
  typedef enum logic [2:0] {
    PMRA_FN_NONE = 3'b000,
    PMRA_FN_OVER_CUR = 3'b001,
    PMRA_FN_UNDER_CUR = 3'b010,
    PMRA_FN_RAIL_OVER = 3'b011,
    PMRA_FN_RAIL_UNDER = 3'b100,
    PMRA_FN_POWER_OVER = 3'b101
  } pmra_func_e;
endpackage

// File: sim/pmra_host_model.sv
`timescale 1ns/1ps
// Serial host stand-in that issues one-word register accesses.
module pmra_host_model
  import pmra_pkg::*;
(
  // Clock.
  input wire logic i_core_clk,
  // Register port toward the block.
  output pmra_reg_req_s o_req,
  input wire logic [15:0] i_rdata,
  // Alert pin as the board sees it.
  input wire logic i_alert_oe,
  output logic o_alert_pin
);
  // The pin has a pull-up, so it is high unless the block pulls it.
  assign o_alert_pin = i_alert_oe ? 1'b0 : 1'b1;
  // The port is idle until the first access.
  initial o_req = '0;
  // Write one word; the strobe lasts a single cycle.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_core_clk);
    o_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge i_core_clk);
    // Released data is scrambled so stale values cannot pass.
    o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
  endtask
  // Read one word; the answer stands from the edge after the strobe.
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_core_clk);
    o_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge i_core_clk);
    o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hFFFF};
    @(posedge i_core_clk);
    v = i_rdata;
  endtask
endmodule // pmra_host_model

// File: sim/test_power_monitor_result_alert.sv
`timescale 1ns/1ps
`include "pmra_consts.svh"
// Self-checking bench for the result and alert block.
module test_power_monitor_result_alert
  import pmra_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  pmra_reg_req_s req;
  pmra_meas_s i_meas = '0;
  logic i_cfg_wr = 1'b0;
  logic i_cfg_pdown = 1'b0;
  logic [15:0] o_rdata;
  logic o_alert_o;
  logic o_alert_oe;
  logic pin;
  logic [15:0] d;
  int err_total = 0;
  int n_tests = 0;
  // A 40 ns clock.
  always #20 i_core_clk = ~i_core_clk;
  pmra_core u_dut (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_req(req),
    .o_rdata(o_rdata),
    .i_meas(i_meas),
    .i_cfg_wr(i_cfg_wr),
    .i_cfg_pdown(i_cfg_pdown),
    .o_alert_o(o_alert_o),
    .o_alert_oe(o_alert_oe)
  );
  pmra_host_model u_host (
    .i_core_clk(i_core_clk),
    .o_req(req),
    .i_rdata(o_rdata),
    .i_alert_oe(o_alert_oe),
    .o_alert_pin(pin)
  );
  // Compare one value and count it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Read a register and compare it.
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  // Compare the board-level alert pin.
  task automatic pchk(input logic exp);
    chk({15'h0000, pin}, {15'h0000, exp});
    // The open-collector data line must never drive high.
    chk({15'h0000, o_alert_o}, 16'h0000);
  endtask
  // One finished conversion, then wait until the alert pin has settled.
  task automatic conv(input logic cu, input logic bu, input logic [15:0] c,
                      input logic [15:0] b);
    @(posedge i_core_clk);
    i_meas <= '{valid: 1'b1, cur_upd: cu, bus_upd: bu, cur: c, bus: b};
    @(posedge i_core_clk);
    i_meas <= '{valid: 1'b0, cur_upd: 1'b0, bus_upd: 1'b0, cur: ~c, bus: ~b};
    repeat (3) @(posedge i_core_clk);
  endtask
  // A configuration write event, with or without power-down.
  task automatic cfg(input logic pwr_down);
    @(posedge i_core_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_pdown <= pwr_down;
    @(posedge i_core_clk);
    i_cfg_wr <= 1'b0;
    i_cfg_pdown <= ~pwr_down;
  endtask
  // Print the counts and the verdict, then stop.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence; every wait is a fixed count from the port timing.
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rchk(`PMRA_OFS_CURRENT, 16'h0000);
    rchk(`PMRA_OFS_POWER, 16'h0000);
    rchk(`PMRA_OFS_MASK, 16'h0000);
    pchk(1'b1);
    // Negative current, bus value with its top bit set on the way in.
    conv(1'b1, 1'b1, 16'hFCE0, 16'h9F40);
    rchk(`PMRA_OFS_CURRENT, 16'hFCE0);
    rchk(`PMRA_OFS_BUS, 16'h1F40);
    rchk(`PMRA_OFS_POWER, 16'h03E8);
    rchk(`PMRA_OFS_MASK, 16'h0008);
    rchk(`PMRA_OFS_MASK, 16'h0000);
    // Largest inputs overflow the power product.
    conv(1'b1, 1'b1, 16'h7FFF, 16'h7FFF);
    rchk(`PMRA_OFS_BUS, 16'h7FFF);
    rchk(`PMRA_OFS_POWER, 16'hA3D7);
    rchk(`PMRA_OFS_MASK, 16'h000C);
    // Current-only update reuses the stored bus value.
    conv(1'b1, 1'b0, 16'h0064, 16'h0000);
    rchk(`PMRA_OFS_POWER, 16'h01FF);
    cfg(1'b1);
    rchk(`PMRA_OFS_MASK, 16'h0008);
    conv(1'b1, 1'b0, 16'h0064, 16'h0000);
    cfg(1'b0);
    rchk(`PMRA_OFS_MASK, 16'h0000);
    u_host.wr(`PMRA_OFS_MASK, 16'hFFFF);
    rchk(`PMRA_OFS_MASK, 16'hFC03);
    // Latched over-current alert survives a clean conversion.
    u_host.wr(`PMRA_OFS_LIMIT, 16'h0064);
    rchk(`PMRA_OFS_LIMIT, 16'h0064);
    u_host.wr(`PMRA_OFS_MASK, 16'h8001);
    conv(1'b1, 1'b0, 16'h00C8, 16'h0000);
    pchk(1'b0);
    conv(1'b1, 1'b0, 16'h0032, 16'h0000);
    pchk(1'b0);
    rchk(`PMRA_OFS_MASK, 16'h8019);
    repeat (2) @(posedge i_core_clk);
    pchk(1'b1);
    // Over-current outranks under-current.
    u_host.wr(`PMRA_OFS_MASK, 16'hC000);
    conv(1'b1, 1'b0, 16'h0032, 16'h0000);
    pchk(1'b1);
    // A negative current is below a positive limit only in signed form.
    u_host.wr(`PMRA_OFS_MASK, 16'h4000);
    conv(1'b1, 1'b0, 16'hFF38, 16'h0000);
    pchk(1'b0);
    conv(1'b1, 1'b0, 16'h00C8, 16'h0000);
    pchk(1'b1);
    // Transparent under-voltage alert comes and goes.
    u_host.wr(`PMRA_OFS_MASK, 16'h1000);
    u_host.wr(`PMRA_OFS_LIMIT, 16'h1F40);
    conv(1'b0, 1'b1, 16'h0000, 16'h1000);
    pchk(1'b0);
    conv(1'b0, 1'b1, 16'h0000, 16'h3000);
    pchk(1'b1);
    rchk(`PMRA_OFS_MASK, 16'h1008);
    // Power over-limit after a bus measurement.
    u_host.wr(`PMRA_OFS_MASK, 16'h0800);
    u_host.wr(`PMRA_OFS_LIMIT, 16'h03E8);
    conv(1'b1, 1'b1, 16'h0320, 16'h1F4A);
    pchk(1'b0);
    rchk(`PMRA_OFS_MASK, 16'h0818);
    conv(1'b1, 1'b1, 16'h0000, 16'h0000);
    rchk(`PMRA_OFS_MASK, 16'h0808);
    // Conversion-ready alert, cleared by reading the select register.
    u_host.wr(`PMRA_OFS_MASK, 16'h0400);
    conv(1'b1, 1'b1, 16'h0000, 16'h0000);
    pchk(1'b0);
    rchk(`PMRA_OFS_MASK, 16'h0408);
    repeat (2) @(posedge i_core_clk);
    pchk(1'b1);
    // Inverted polarity pulls the pin while idle.
    u_host.wr(`PMRA_OFS_MASK, 16'h0002);
    repeat (3) @(posedge i_core_clk);
    pchk(1'b0);
    complete_run();
  end
endmodule // test_power_monitor_result_alert
